// File: include/sdb_pkg.sv
// Constants, states and carrier types for the single-wire debug bit engine.
// Assumes all cycle counts except the strap counts are in debug-clock ticks, not system clock edges.
package sdb_pkg;

  // ----------------------------------------
  // Bit timing in debug-clock cycles
  // ----------------------------------------
  localparam logic [9:0] BIT_CYC = 10'h010;
  localparam logic [9:0] SAMPLE_CYC = 10'h00a;
  localparam logic [9:0] ONE_PULSE_CYC = 10'h007;
  localparam logic [9:0] ZERO_LOW_CYC = 10'h00d;
  localparam logic [9:0] TIMEOUT_CYC = 10'h200;
  localparam logic [9:0] SYNC_REQ_CYC = 10'h080;
  localparam logic [9:0] SYNC_GAP_CYC = 10'h010;
  localparam logic [9:0] SYNC_LOW_CYC = 10'h080;

  // ----------------------------------------
  // Framing and reset values
  // ----------------------------------------
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] STRAP_WAIT = 2'h2;
  localparam logic [1:0] STRAP_DONE = 2'h3;
  localparam logic PIN_IDLE = 1'b1;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_TX,
    ST_SYNC_HIGH,
    ST_SYNC_GAP,
    ST_SYNC_LOW,
    ST_SYNC_PULSE
  } sdb_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sdb_byte_t;

endpackage

// File: tb/sdb_pod.sv
// Behavioural debug pod that hosts the single-wire link.
// Assumes the bench resolves the wire with a pullup; div is clk edges per debug cycle.
`timescale 1ns/100ps
module sdb_pod (
  // Clock
  input wire logic clk,
  // Wire
  input wire logic pin,
  output logic pod_out,
  output logic pod_oe
);
  int div = 1;

  initial begin
    pod_out = 1'b1;
    pod_oe = 1'b0;
  end

  task automatic tk(input int n);
    repeat (n * div) @(posedge clk);
  endtask

  task automatic hold(input logic lo);
    @(posedge clk);
    pod_out <= 1'b0;
    pod_oe <= lo;
  endtask

  // A one is pulled high early by active drive; a zero stays low past the sample point.
  task automatic put_bit(input logic b);
    pod_oe <= 1'b1;
    pod_out <= 1'b0;
    tk(b ? 4 : 14);
    pod_out <= 1'b1;
    tk(b ? 12 : 2);
  endtask

  task automatic put_byte(input logic [7:0] d);
    @(posedge clk);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    pod_oe <= 1'b0;
    tk(1);
  endtask

  task automatic get_bit(output logic b);
    pod_oe <= 1'b1;
    pod_out <= 1'b0;
    tk(2);
    pod_oe <= 1'b0;
    tk(8);
    #1 b = pin;
    tk(10);
  endtask

  task automatic get_byte(output logic [7:0] d);
    @(posedge clk);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
  endtask

  // Long low request, speedup pulse, release, then time the low answer.
  task automatic probe(output int n);
    @(posedge clk);
    pod_oe <= 1'b1;
    pod_out <= 1'b0;
    tk(130);
    pod_out <= 1'b1;
    tk(1);
    pod_oe <= 1'b0;
    n = 0;
    while (pin !== 1'b0 && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
    n = 0;
    while (pin === 1'b0 && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
endmodule

// File: tb/tb_single_wire_debug_bit_link.sv
// Self-checking bench for the debug bit engine driven by the pod model.
// Assumes sdb_pkg is compiled first; clk is 100 MHz.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_single_wire_debug_bit_link;
  import sdb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic debug_clock_select = 1'b0;
  logic alt_tick = 1'b0;
  logic debug_wire_pin_out, debug_wire_pin_oe, pod_out, pod_oe, pin;
  sdb_byte_t cmd, rx;
  logic cmd_halted_only = 1'b0;
  logic cmd_accept, cmd_reject, cmd_active, abort, tx_ready, halted_debug_mode;
  logic cmd_done = 1'b0;
  logic tx_load = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic halt_req = 1'b0;
  logic resume_req = 1'b0;
  logic [7:0] cdat;
  logic [7:0] rdat;
  logic cacc, crej;
  logic bad7 = 1'b0;
  logic hsend = 1'b0;
  int nab = 0;
  int compares = 0;
  int miscompares = 0;

  always #5 clk = ~clk;
  always @(posedge clk) alt_tick <= ~alt_tick;
  // Pullup wins only while nobody drives the wire.
  assign pin = debug_wire_pin_oe ? debug_wire_pin_out : (pod_oe ? pod_out : 1'b1);

  sdb_bit_engine sdb_bit_engine_inst (.clk(clk), .rst(rst),
    .debug_clock_select(debug_clock_select), .alt_tick(alt_tick),
    .debug_wire_pin_in(pin), .debug_wire_pin_out(debug_wire_pin_out),
    .debug_wire_pin_oe(debug_wire_pin_oe), .cmd(cmd), .cmd_halted_only(cmd_halted_only),
    .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .cmd_done(cmd_done), .rx(rx),
    .cmd_active(cmd_active), .abort(abort), .tx_load(tx_load), .tx_data(tx_data),
    .tx_ready(tx_ready), .halt_req(halt_req), .resume_req(resume_req),
    .halted_debug_mode(halted_debug_mode));
  sdb_pod sdb_pod_inst (.clk(clk), .pin(pin), .pod_out(pod_out), .pod_oe(pod_oe));

  always @(posedge clk) begin
    if (cmd.valid === 1'b1) begin
      cdat <= cmd.data;
      cacc <= cmd_accept;
      crej <= cmd_reject;
    end
    if (rx.valid === 1'b1) rdat <= rx.data;
    if (abort === 1'b1) nab <= nab + 1;
    if (hsend && debug_wire_pin_oe !== 1'b0) bad7 <= 1'b1;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_strap(input logic lo);
    sdb_pod_inst.hold(lo);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1 `CHK("halted", lo, halted_debug_mode)
    sdb_pod_inst.hold(1'b0);
    repeat (600) @(posedge clk);
    $display("strap %0d done", lo);
  endtask

  task automatic t_cmd(input logic [7:0] d, input logic ho);
    logic ok;
    ok = halted_debug_mode | ~ho;
    cmd_halted_only <= ho;
    hsend = 1'b1;
    sdb_pod_inst.put_byte(d);
    hsend = 1'b0;
    repeat (4) @(posedge clk);
    #1 `CHK("cmd_data", d, cdat)
    `CHK("accept", ok, cacc)
    `CHK("reject", ~ok, crej)
    `CHK("active", ok, cmd_active)
    `CHK("oe_rx", 1'b0, bad7)
    $display("cmd %h done", d);
  endtask

  task automatic t_data(input logic [7:0] d);
    logic [7:0] c;
    c = cdat;
    hsend = 1'b1;
    sdb_pod_inst.put_byte(d);
    hsend = 1'b0;
    repeat (4) @(posedge clk);
    #1 `CHK("rx_data", d, rdat)
    `CHK("cmd_kept", c, cdat)
    `CHK("active_kept", 1'b1, cmd_active)
    `CHK("oe_rx", 1'b0, bad7)
    $display("data %h done", d);
  endtask

  task automatic t_done();
    @(posedge clk) cmd_done <= 1'b1;
    @(posedge clk) cmd_done <= 1'b0;
  endtask

  task automatic t_mode(input logic h);
    @(posedge clk);
    if (h) halt_req <= 1'b1;
    else resume_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    resume_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK("mode", h, halted_debug_mode)
  endtask

  task automatic t_tx(input logic [7:0] d);
    logic [7:0] g;
    @(posedge clk);
    tx_load <= 1'b1;
    tx_data <= d;
    @(posedge clk);
    tx_load <= 1'b0;
    sdb_pod_inst.tk(16);
    sdb_pod_inst.get_byte(g);
    `CHK("tx_byte", d, g)
    `CHK("tx_ready", 1'b1, tx_ready)
    $display("tx %h done", d);
  endtask

  task automatic t_timeout();
    int n0;
    logic h;
    h = halted_debug_mode;
    n0 = nab;
    t_cmd(8'hc4, 1'b0);
    repeat (480) @(posedge clk);
    #1 `CHK("early_abort", n0, nab)
    repeat (30) @(posedge clk);
    #1 `CHK("abort", n0 + 1, nab)
    `CHK("active_off", 1'b0, cmd_active)
    `CHK("mode_kept", h, halted_debug_mode)
    $display("timeout done");
  endtask

  task automatic t_probe();
    int n;
    sdb_pod_inst.probe(n);
    `CHK("probe_low", 128, n)
    $display("probe done");
  endtask

  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    final_report();
  end

  initial begin
    t_strap(1'b1);
    t_cmd(8'h6f, 1'b1);
    t_done();
    t_mode(1'b0);
    t_cmd(8'h4b, 1'b1);
    t_strap(1'b0);
    t_cmd(8'he4, 1'b0);
    t_tx(8'ha6);
    t_done();
    t_mode(1'b1);
    t_cmd(8'h10, 1'b1);
    t_data(8'h95);
    t_done();
    t_timeout();
    @(posedge clk) debug_clock_select <= 1'b1;
    sdb_pod_inst.div = 2;
    t_cmd(8'h5a, 1'b0);
    t_tx(8'h3c);
    t_done();
    @(posedge clk) debug_clock_select <= 1'b0;
    sdb_pod_inst.div = 1;
    t_probe();
    final_report();
  end
endmodule

// File: verilog/sdb_bit_engine.sv
// Bit engine of the single-wire background debug controller.
// Assumes a command layer outside classifies command codes and executes them.
`timescale 1ns/100ps
// What this block does
// RULE1: The host starts every bit, both directions, with a falling edge.
// RULE2: Bits travel most significant first, nominally sixteen debug cycles each.
// RULE3: After 512 cycles without a host edge, abort the command, keep mode.
// RULE4: A select bit picks bus clock or alternate clock as debug clock.
// RULE5: The host falling edge is synchronized; perceived start lags slightly.
// RULE6: Received bits are sampled ten cycles after the perceived start.
// RULE7: The device never drives the pin while the host sends.
// RULE8: The host holds the pin low two cycles when reading a bit.
// RULE9: A one is returned as a brief high pulse seven cycles in.
// RULE10: A zero is returned as thirteen low cycles, then a brief high.
// RULE11: The host samples returned bits about ten cycles in.
// RULE12: Pin low at reset release starts halted mode; high starts running.
// RULE13: Any-time commands always accepted; halted-only ones only when halted.
// RULE14: Any-time commands reach memory and the controller status register.
// RULE15: Halted commands reach CPU registers, single step and resume.
// RULE16: Pseudo open drain pin; rising edges forced by brief high pulses.
// RULE17: A rate probe request is answered with a timed pulse.
// RULE18: Debug traffic works while running, with no reset needed.
// RULE19: Rate probe answer: 128 cycles low, then one cycle high.
// RULE20: Host probes with at least 128 slow cycles low, pulse, release.
// RULE21: The host waits sixteen cycles in a delay slot.
// RULE22: The timeout counter restarts on host edges, cleared when idle.
// RULE23: The pin passes two synchronizer stages before any use.
module sdb_bit_engine (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Debug clock choice
  input wire logic debug_clock_select,
  input wire logic alt_tick,
  // Debug wire pin
  input wire logic debug_wire_pin_in,
  output logic debug_wire_pin_out,
  output logic debug_wire_pin_oe,
  // Received command and data bytes
  output sdb_pkg::sdb_byte_t cmd,
  input wire logic cmd_halted_only,
  output logic cmd_accept,
  output logic cmd_reject,
  input wire logic cmd_done,
  output sdb_pkg::sdb_byte_t rx,
  output logic cmd_active,
  output logic abort,
  // Bytes returned to the host
  input wire logic tx_load,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Operating mode
  input wire logic halt_req,
  input wire logic resume_req,
  output logic halted_debug_mode
);
  import sdb_pkg::*;

  sdb_state_t state;
  logic tick;
  logic pin_s;
  logic pin_prev;
  logic fall;
  logic sync_seen;
  logic [9:0] cnt;
  logic [9:0] low_cnt;
  logic [9:0] idle_cnt;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx_shift;
  logic [3:0] tx_left;
  logic [1:0] strap_cnt;
  logic rx_bit_done;
  logic tx_bit_done;
  logic cmd_taken;

  // ----------------------------------------
  // Debug clock and pin input
  // ----------------------------------------
  assign tick = debug_clock_select ? alt_tick : 1'b1; // RULE4

  sdb_sync u_sync ( // RULE23
    .clk(clk),
    .rst(rst),
    .din(debug_wire_pin_in),
    .dout(pin_s)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_prev <= PIN_IDLE;
    end else if (tick) begin
      pin_prev <= pin_s;
    end
  end

  // Edges are ignored until the mode strap is read, so a strap low held through reset
  // does not look like the start of a bit.
  assign fall = tick && pin_prev && !pin_s && (strap_cnt == STRAP_DONE); // RULE1 RULE5

  // A host low far longer than any bit is a rate probe request.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt <= '0;
    end else if (tick) begin
      if (pin_s || debug_wire_pin_oe) begin
        low_cnt <= '0;
      end else if (low_cnt != SYNC_REQ_CYC) begin
        low_cnt <= low_cnt + 10'h001;
      end
    end
  end

  assign sync_seen = (low_cnt == SYNC_REQ_CYC); // RULE17

  // ----------------------------------------
  // Bit timing state machine
  // ----------------------------------------
  assign rx_bit_done = (state == ST_RX) && tick && (cnt == SAMPLE_CYC);
  assign tx_bit_done = (state == ST_TX) && tick && (cnt == ZERO_LOW_CYC);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      cnt <= '0;
    end else if (sync_seen && (state == ST_IDLE || state == ST_RX)) begin
      state <= ST_SYNC_HIGH;
      cnt <= '0;
    end else if (tick) begin
      unique case (state)
        ST_IDLE: begin
          cnt <= '0;
          if (fall) begin
            state <= (tx_left != 4'h0) ? ST_TX : ST_RX; // RULE2
          end
        end
        ST_RX: begin
          cnt <= cnt + 10'h001;
          if (cnt == SAMPLE_CYC) begin
            state <= ST_IDLE; // RULE6
          end
        end
        ST_TX: begin
          cnt <= cnt + 10'h001;
          if (cnt == ZERO_LOW_CYC) begin
            state <= ST_IDLE;
          end
        end
        ST_SYNC_HIGH: begin
          cnt <= '0;
          if (pin_s) begin
            state <= ST_SYNC_GAP;
          end
        end
        ST_SYNC_GAP: begin
          cnt <= cnt + 10'h001;
          if (cnt == SYNC_GAP_CYC - 10'h001) begin
            state <= ST_SYNC_LOW;
            cnt <= '0;
          end
        end
        ST_SYNC_LOW: begin
          cnt <= cnt + 10'h001;
          if (cnt == SYNC_LOW_CYC - 10'h001) begin
            state <= ST_SYNC_PULSE; // RULE19
          end
        end
        ST_SYNC_PULSE: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // The pin is only ever driven for short, timed spans; otherwise the pullup holds it.
  always_comb begin
    debug_wire_pin_oe = 1'b0; // RULE7 RULE16
    debug_wire_pin_out = 1'b1;
    unique case (state)
      ST_TX: begin
        if (tx_shift[7]) begin
          debug_wire_pin_oe = (cnt == ONE_PULSE_CYC); // RULE9
        end else begin
          debug_wire_pin_oe = 1'b1; // RULE10
          debug_wire_pin_out = (cnt == ZERO_LOW_CYC);
        end
      end
      ST_SYNC_LOW: begin
        debug_wire_pin_oe = 1'b1; // RULE19
        debug_wire_pin_out = 1'b0;
      end
      ST_SYNC_PULSE: begin
        debug_wire_pin_oe = 1'b1;
      end
      default: begin
        debug_wire_pin_oe = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Framing, command gating and timeout
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift <= '0;
      bit_cnt <= '0;
      cmd <= '0;
      rx <= '0;
    end else begin
      cmd.valid <= 1'b0;
      rx.valid <= 1'b0;
      if (abort || sync_seen) begin
        bit_cnt <= '0;
      end else if (rx_bit_done) begin
        shift <= {shift[6:0], pin_s}; // RULE2
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == LAST_BIT) begin
          if (!cmd_taken) begin
            cmd <= '{valid: 1'b1, data: {shift[6:0], pin_s}};
          end else begin
            rx <= '{valid: 1'b1, data: {shift[6:0], pin_s}};
          end
        end
      end
    end
  end

  // Any-time commands pass in either mode; halted-only ones need halted mode.
  assign cmd_accept = cmd.valid && (halted_debug_mode || !cmd_halted_only); // RULE13 RULE14 RULE15
  assign cmd_reject = cmd.valid && !halted_debug_mode && cmd_halted_only; // RULE13

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_active <= 1'b0;
    end else if (abort || sync_seen || cmd_reject) begin
      cmd_active <= 1'b0;
    end else if (state == ST_IDLE && fall && tx_left == 4'h0) begin
      cmd_active <= 1'b1; // RULE18
    end else if (cmd_done) begin
      cmd_active <= 1'b0;
    end
  end

  // The first byte after idle is the command; later bytes are its data.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_taken <= 1'b0;
    end else if (abort || sync_seen || cmd_done || cmd_reject) begin
      cmd_taken <= 1'b0;
    end else if (cmd.valid) begin
      cmd_taken <= 1'b1; // RULE2
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_cnt <= '0;
    end else if (!cmd_active || fall) begin
      idle_cnt <= '0; // RULE22
    end else if (tick) begin
      idle_cnt <= idle_cnt + 10'h001;
    end
  end

  // The abort touches only framing state; mode and memory stay as they were.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      abort <= 1'b0;
    end else begin
      abort <= cmd_active && tick && !fall && (idle_cnt == TIMEOUT_CYC - 10'h001); // RULE3
    end
  end

  // ----------------------------------------
  // Return byte shifter
  // ----------------------------------------
  assign tx_ready = (tx_left == 4'h0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_shift <= '0;
      tx_left <= '0;
    end else if (abort || sync_seen) begin
      tx_left <= '0;
    end else if (tx_load && tx_ready) begin // RULE21
      tx_shift <= tx_data;
      tx_left <= BYTE_BITS;
    end else if (tx_bit_done) begin
      tx_shift <= {tx_shift[6:0], 1'b0}; // RULE2
      tx_left <= tx_left - 4'h1;
    end
  end

  // ----------------------------------------
  // Operating mode
  // ----------------------------------------
  // The strap is read once the synchronizer holds the released pin level.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_cnt <= '0;
      halted_debug_mode <= 1'b0;
    end else if (strap_cnt != STRAP_DONE) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == STRAP_WAIT) begin
        halted_debug_mode <= !pin_s; // RULE12
      end
    end else if (halt_req) begin
      halted_debug_mode <= 1'b1;
    end else if (resume_req) begin
      halted_debug_mode <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_RX_NO_DRIVE: assert property (state == ST_RX |-> !debug_wire_pin_oe) // RULE7
    else $error("pin driven while host sends");
  AST_SAMPLE_TEN: assert property (rx_bit_done && !sync_seen |=> shift[0] == $past(pin_s)) // RULE6
    else $error("bit not sampled at count ten");
  AST_ZERO_LOW: assert property (state == ST_TX && !tx_shift[7] && cnt < ZERO_LOW_CYC
      |-> debug_wire_pin_oe && !debug_wire_pin_out) // RULE10
    else $error("zero bit not held low");
  AST_ONE_PULSE: assert property (state == ST_TX && tx_shift[7]
      |-> debug_wire_pin_oe == (cnt == ONE_PULSE_CYC) && debug_wire_pin_out) // RULE9
    else $error("one bit pulse misplaced");
  AST_TIMEOUT: assert property (cmd_active && tick && !fall && idle_cnt == TIMEOUT_CYC - 10'h001
      |=> abort ##1 !cmd_active) // RULE3
    else $error("timeout did not abort");
  AST_TIMEOUT_CLR: assert property (fall || !cmd_active |=> idle_cnt == 10'h000) // RULE22
    else $error("timeout counter not restarted");
  AST_REJECT: assert property (cmd.valid && cmd_halted_only && !halted_debug_mode
      |-> cmd_reject && !cmd_accept ##1 !cmd_active) // RULE13
    else $error("halted-only command accepted while running");
  AST_SYNC_LOW: assert property ($rose(state == ST_SYNC_LOW) && !debug_clock_select
      |-> (debug_wire_pin_oe && !debug_wire_pin_out) [*8]) // RULE19
    else $error("probe answer not driven low");
  AST_DRIVE_ONLY_TIMED: assert property (debug_wire_pin_oe
      |-> state inside {ST_TX, ST_SYNC_LOW, ST_SYNC_PULSE}) // RULE16
    else $error("pin driven outside timed span");
  AST_START: assert property (state == ST_IDLE && fall && !sync_seen
      |=> state inside {ST_RX, ST_TX} && cnt == 10'h000) // RULE5
    else $error("bit start not taken on falling edge");

  COV_RX_BYTE: cover property (rx.valid);
  COV_CMD_OK: cover property (cmd_accept);
  COV_TX_BYTE: cover property (tx_bit_done && tx_left == 4'h1);
  COV_PROBE: cover property (state == ST_SYNC_PULSE);
endmodule

// File: verilog/sdb_sync.sv
// Two-stage synchronizer for the debug wire input level.
// Assumes the pin idles high through the internal pullup.
`timescale 1ns/100ps
module sdb_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level in and out
  input wire logic din,
  output logic dout
);
  import sdb_pkg::*;

  logic stage1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= PIN_IDLE;
      dout <= PIN_IDLE;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule
